// [sif_pkg.sv]
package sif_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_I2C_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  // spi_config_control and i2c_own_address share one location
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_TOUT = 8'h10;
  localparam logic [7:0] RST_MODE = 8'hE0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hEF;
  localparam logic [7:0] STAT_WMASK = 8'h98;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_LO = 5;
  localparam int DEB_LO = 2;
  localparam int EN_BIT = 1;
  localparam int ICF_BIT = 0;
  localparam int POL_BIT = 5;
  localparam int EDGE_BIT = 4;
  localparam int ORDER_BIT = 3;
  localparam int SELECT_PIN_ENABLE_BIT = 2;
  localparam int WRITE_COLLISION_FLAG_BIT = 1;
  localparam int TRF_BIT = 0;
  localparam int HCF_BIT = 7;
  localparam int BUSY_BIT = 5;
  localparam int HTX_BIT = 4;
  localparam int NOACK_BIT = 3;

  // ----------------------------------------------------------------
  // pins seen through the synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_W = 5;
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SCS = 2;
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 4;
  localparam logic [4:0] SYNC_RST = 5'h1C;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] WORD_LAST = 4'h7;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [3:0] I2C_ACK = 4'h8;
  localparam logic [3:0] I2C_AFTER = 4'h9;
  localparam logic [2:0] DEB_SHORT = 3'h2;
  localparam logic [2:0] DEB_LONG = 3'h4;

  typedef enum logic [2:0] {
    MODE_DIV4 = 3'b000,
    MODE_DIV16 = 3'b001,
    MODE_DIV64 = 3'b010,
    MODE_SUB = 3'b011,
    MODE_TIMER = 3'b100,
    MODE_SPI_SLAVE = 3'b101,
    MODE_I2C_SLAVE = 3'b110,
    MODE_UNUSED = 3'b111
  } sif_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } sif_state_t;

endpackage : sif_pkg

// [sif_sync_if.sv]
`timescale 1ns/1ps
interface sif_sync_if;
  logic [1:0] deb_sel;
  logic sck_s;
  logic sdi_s;
  logic scs_n_s;
  logic scl_f;
  logic sda_s;
  modport filt (input deb_sel, output sck_s, sdi_s, scs_n_s, scl_f, sda_s);
  modport core (output deb_sel, input sck_s, sdi_s, scs_n_s, scl_f, sda_s);
endinterface : sif_sync_if

// [sif_sync_filter.sv]
`timescale 1ns/1ps
module sif_sync_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sif_pkg::PIN_W-1:0] pins_in,
  sif_sync_if.filt sy
);
  import sif_pkg::*;

  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s1_next;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s2_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] need;
  logic scl_reg;
  logic scl_next;

  // ----------------------------------------------------------------
  // two-stage synchronisers, one per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++)
    begin : g_sync
      assign s1_next[g] = pins_in[g];
      assign s2_next[g] = s1_reg[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // clock-line debounce
  // ----------------------------------------------------------------
  always_comb
  begin
    case (sy.deb_sel)
      2'b00: need = 3'h0;
      2'b01: need = DEB_SHORT; // [R19]
      default: need = DEB_LONG;
    endcase
    cnt_next = 3'h0;
    scl_next = scl_reg;
    // a new level must persist for need cycles before it is accepted
    if (s2_reg[PIN_SCL] != scl_reg)
    begin
      if (cnt_reg + 3'h1 >= need)
        scl_next = s2_reg[PIN_SCL];
      else
        cnt_next = cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      cnt_reg <= 3'h0;
      scl_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      cnt_reg <= cnt_next;
      scl_reg <= scl_next;
    end
  end

  assign sy.sck_s = s2_reg[PIN_SCK];
  assign sy.sdi_s = s2_reg[PIN_SDI];
  assign sy.scs_n_s = s2_reg[PIN_SCS];
  assign sy.sda_s = s2_reg[PIN_SDA];
  assign sy.scl_f = scl_reg;

endmodule : sif_sync_filter

// [sif_top.sv]
`timescale 1ns/1ps
// Summary of operation
// R1: master starts shifting when data is written
// R2: completed word sets transfer flag, software clears
// R3: slave shifts on each external clock pulse
// R4: disabled interface releases all its pins
// R5: select pin floats unless select enable set
// R6: enabled idle: data input floats, output high
// R7: master clock idles at the polarity setting
// R8: slave clock pin is an input only
// R9: master makes the clock; no write, no transfer
// R10: bit order must match on both ends
// R11: software configures mode, then order, then enable
// R12: received word reaches data register when complete
// R13: external master selects, then clocks slave data
// R14: write during transfer flags collision, discarded
// R15: hardware only sets collision flag
// R16: software polls flag, reads data, clears flag
// R17: two-wire side is slave only, both directions
// R18: two-wire outputs only ever pull low
// R19: optional clock debounce of two or four cycles
// R20: system clock must meet two-wire minimums
// R21: mode field selects master clock, slave, two-wire
// R22: debounce field: none, two, or four cycles
// R23: polarity and edge bits pick sampling edge
// R24: bit order: high is msb first
// R25: each transfer is exactly eight clock pulses
// R26: reset clears flags; collision stays until cleared
module sif_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sif_pkg::ADDR_W-1:0] paddr,
  input wire logic [sif_pkg::DATA_W-1:0] pwdata,
  output logic [sif_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_tick,
  input wire logic timer_tick,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic slave_select_n_in,
  output logic slave_select_n_out,
  output logic slave_select_n_oe_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import sif_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_valid(input logic [ADDR_W-1:0] a);
    reg_valid = (a == OFS_MODE) || (a == OFS_I2C_STAT) ||
      (a == OFS_DATA) || (a == OFS_CFG) || (a == OFS_TOUT);
  endfunction : reg_valid

  // the sampling edge is the rising one when polarity equals edge select
  function automatic logic is_capture(input logic pol, input logic edg,
                                      input logic rise);
    is_capture = (rise == (pol == edg)); // [R23]
  endfunction : is_capture

  sif_sync_if sy ();

  sif_sync_filter u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .pins_in({sda_in, scl_in, slave_select_n_in, sdi_in, sck_in}),
    .sy(sy)
  );

  logic [7:0] mode_reg, mode_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] tout_reg, tout_next;
  logic [7:0] buf_reg, buf_next;
  logic [31:0] prdata_reg, prdata_next;
  sif_state_t state_reg, state_next;
  logic [5:0] div_reg, div_next;
  logic [3:0] edge_reg, edge_next;
  logic [3:0] cap_reg, cap_next;
  logic [3:0] bit_reg, bit_next;
  logic sck_reg, sck_next;
  logic sdo_reg, sdo_next;
  logic sck_prev_reg, sck_prev_next;
  logic scl_prev_reg, scl_prev_next;
  logic sda_prev_reg, sda_prev_next;
  logic sda_low_reg, sda_low_next;

  sif_mode_t mode;
  logic en, is_master, is_slave, is_i2c, spi_on;
  logic pol, edg, msb_first, select_pin_enable;
  logic wr, rd_setup, busy;
  logic [5:0] half;
  logic tick, m_edge, s_edge, s_sel, ev, ev_rise, cap_ev;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  assign mode = sif_mode_t'(mode_reg[MODE_LO+2:MODE_LO]);
  assign en = mode_reg[EN_BIT];
  assign is_master = en && (mode <= MODE_TIMER); // [R21]
  assign is_slave = en && (mode == MODE_SPI_SLAVE); // [R21]
  assign is_i2c = en && (mode == MODE_I2C_SLAVE); // [R21] [R17]
  assign spi_on = is_master || is_slave;
  assign pol = cfg_reg[POL_BIT];
  assign edg = cfg_reg[EDGE_BIT];
  assign msb_first = cfg_reg[ORDER_BIT];
  assign select_pin_enable = cfg_reg[SELECT_PIN_ENABLE_BIT];
  assign sy.deb_sel = mode_reg[DEB_LO+1:DEB_LO]; // [R22]
  assign busy = (state_reg == ST_RUN);
  assign wr = psel && penable && pwrite && reg_valid(paddr);
  assign rd_setup = psel && !penable;

  // ----------------------------------------------------------------
  // master clock divider and edge events
  // ----------------------------------------------------------------
  always_comb
  begin
    case (mode)
      MODE_DIV4: half = HALF_DIV4;
      MODE_DIV16: half = HALF_DIV16;
      default: half = HALF_DIV64;
    endcase
  end

  // external sources give one enable pulse per half period
  assign tick = (mode == MODE_SUB) ? sub_tick :
                (mode == MODE_TIMER) ? timer_tick :
                (div_reg == half - 6'h01);
  assign m_edge = is_master && busy && tick; // [R9]
  // select line only gates the slave when its enable bit is set
  assign s_sel = !select_pin_enable || !sy.scs_n_s; // [R5]
  assign s_edge = is_slave && s_sel && (sy.sck_s != sck_prev_reg); // [R3]
  assign ev = m_edge || s_edge;
  assign ev_rise = is_master ? !sck_reg : sy.sck_s;
  assign cap_ev = ev && is_capture(pol, edg, ev_rise);

  assign scl_rise = is_i2c && sy.scl_f && !scl_prev_reg;
  assign scl_fall = is_i2c && !sy.scl_f && scl_prev_reg;
  assign i2c_start = is_i2c && sy.scl_f && sda_prev_reg && !sy.sda_s;
  assign i2c_stop = is_i2c && sy.scl_f && !sda_prev_reg && sy.sda_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    stat_next = stat_reg;
    cfg_next = cfg_reg;
    data_next = data_reg;
    tout_next = tout_reg;
    buf_next = buf_reg;
    prdata_next = prdata_reg;
    state_next = state_reg;
    div_next = div_reg;
    edge_next = edge_reg;
    cap_next = cap_reg;
    bit_next = bit_reg;
    sck_next = sck_reg;
    sdo_next = sdo_reg;
    sck_prev_next = sy.sck_s;
    scl_prev_next = sy.scl_f;
    sda_prev_next = sy.sda_s;
    sda_low_next = sda_low_reg;

    if (rd_setup)
    begin
      case (paddr)
        OFS_MODE: prdata_next = {24'h000000, mode_reg};
        OFS_I2C_STAT: prdata_next = {24'h000000, stat_reg};
        OFS_DATA: prdata_next = {24'h000000, data_reg};
        OFS_CFG: prdata_next = {24'h000000, cfg_reg};
        OFS_TOUT: prdata_next = {24'h000000, tout_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end

    // software writes come first so that hardware sets below win
    if (wr)
    begin
      case (paddr)
        OFS_MODE: mode_next = pwdata[7:0] & MODE_WMASK;
        OFS_I2C_STAT: stat_next = (stat_reg & ~STAT_WMASK) |
                                  (pwdata[7:0] & STAT_WMASK);
        OFS_CFG: cfg_next = pwdata[7:0]; // [R26]
        OFS_TOUT: tout_next = pwdata[7:0];
        OFS_DATA:
        begin
          if (spi_on && busy)
            cfg_next[WRITE_COLLISION_FLAG_BIT] = 1'b1; // [R14] [R15]
          else
          begin
            data_next = pwdata[7:0];
            buf_next = pwdata[7:0];
            if (spi_on)
            begin
              // first bit is presented before the first clock edge
              sdo_next = msb_first ? pwdata[7] : pwdata[0]; // [R24]
              cap_next = 4'h0;
              edge_next = 4'h0;
              div_next = 6'h00;
            end
            if (is_master)
              state_next = ST_RUN; // [R1] [R9]
          end
        end
        default: ;
      endcase
    end

    // spi clock generation
    if (is_master && busy)
      div_next = tick ? 6'h00 : div_reg + 6'h01;
    if (m_edge)
    begin
      sck_next = !sck_reg;
      edge_next = edge_reg + 4'h1;
    end
    else if (!busy)
      sck_next = !pol; // [R7]

    if (s_edge && !busy)
      state_next = ST_RUN; // [R3]

    // shift engine shared by master and slave
    if (cap_ev)
    begin
      buf_next = msb_first ? {buf_reg[6:0], sy.sdi_s} :
                             {sy.sdi_s, buf_reg[7:1]}; // [R24] [R12]
      cap_next = cap_reg + 4'h1;
    end
    else if (ev && (cap_reg != 4'h0))
      sdo_next = msb_first ? buf_reg[7] : buf_reg[0];

    // eight captures end a slave word; sixteen edges end a master word
    if ((is_slave && cap_ev && (cap_reg == WORD_LAST)) ||
        (m_edge && (edge_reg == EDGE_LAST)))
    begin
      data_next = buf_next; // [R12] [R25]
      cfg_next[TRF_BIT] = 1'b1; // [R2]
      state_next = ST_IDLE;
      sdo_next = 1'b1; // [R6]
    end

    // slave deselected mid-word: word is dropped and flagged
    if (is_slave && busy && select_pin_enable && sy.scs_n_s)
    begin
      state_next = ST_IDLE;
      cap_next = 4'h0;
      sdo_next = 1'b1;
      mode_next[ICF_BIT] = 1'b1;
    end

    // two-wire slave byte engine, msb first with acknowledge
    if (i2c_start)
    begin
      stat_next[BUSY_BIT] = 1'b1;
      bit_next = 4'h0;
      sda_low_next = 1'b0;
    end
    else if (i2c_stop)
    begin
      stat_next[BUSY_BIT] = 1'b0;
      sda_low_next = 1'b0;
    end
    else if (scl_rise && (bit_reg < I2C_ACK))
    begin
      buf_next = {buf_reg[6:0], sy.sda_s};
      bit_next = bit_reg + 4'h1;
    end
    else if (scl_fall)
    begin
      if (bit_reg == I2C_ACK)
      begin
        if (!stat_reg[HTX_BIT])
          data_next = buf_reg;
        stat_next[HCF_BIT] = 1'b1;
        sda_low_next = !stat_reg[HTX_BIT] && !stat_reg[NOACK_BIT]; // [R17]
        bit_next = I2C_AFTER;
      end
      else
      begin
        if (bit_reg == I2C_AFTER)
          bit_next = 4'h0;
        sda_low_next = stat_reg[HTX_BIT] && !buf_reg[7]; // [R17]
      end
    end

    // disabled interface: engines parked
    if (!spi_on)
    begin
      state_next = ST_IDLE;
      cap_next = 4'h0;
      sdo_next = 1'b1;
    end
    if (!is_i2c)
    begin
      sda_low_next = 1'b0;
      stat_next[BUSY_BIT] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= RST_MODE;
      stat_reg <= RST_ZERO;
      cfg_reg <= RST_ZERO; // [R26]
      data_reg <= RST_ZERO;
      tout_reg <= RST_ZERO;
      buf_reg <= RST_ZERO;
      prdata_reg <= 32'h00000000;
      state_reg <= ST_IDLE;
      div_reg <= 6'h00;
      edge_reg <= 4'h0;
      cap_reg <= 4'h0;
      bit_reg <= 4'h0;
      sck_reg <= 1'b1;
      sdo_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      stat_reg <= stat_next;
      cfg_reg <= cfg_next;
      data_reg <= data_next;
      tout_reg <= tout_next;
      buf_reg <= buf_next;
      prdata_reg <= prdata_next;
      state_reg <= state_next;
      div_reg <= div_next;
      edge_reg <= edge_next;
      cap_reg <= cap_next;
      bit_reg <= bit_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      sck_prev_reg <= sck_prev_next;
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
      sda_low_reg <= sda_low_next;
    end
  end

  // ----------------------------------------------------------------
  // bus answer and pins
  // ----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_valid(paddr);

  // a released pin has its enable high; data input is never driven
  assign sck_out = sck_reg;
  assign sck_oe_n = !is_master; // [R4] [R8]
  assign sdo_out = sdo_reg; // [R6]
  assign sdo_oe_n = !spi_on; // [R4]
  assign slave_select_n_out = !busy;
  assign slave_select_n_oe_n = !(is_master && select_pin_enable); // [R5] [R4]
  // open-drain: output value is always low, only the enable moves
  assign scl_out = 1'b0;
  assign scl_oe_n = 1'b1; // [R18]
  assign sda_out = 1'b0;
  assign sda_oe_n = !sda_low_reg; // [R18]

endmodule : sif_top

// [sif_asserts.sv]
`timescale 1ns/1ps
module sif_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sif_pkg::ADDR_W-1:0] paddr,
  input wire logic [sif_pkg::DATA_W-1:0] pwdata,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic slave_select_n_out,
  input wire logic slave_select_n_oe_n,
  input wire logic scl_out,
  input wire logic sda_out
);
  import sif_pkg::*;
  // ----------------------------------------------------------------
  // shadow of settings, seen only through bus writes
  // ----------------------------------------------------------------
  logic en_q, pol_q, select_pin_enable_q, sck_d, wr, mst;
  logic [2:0] md_q;
  logic [4:0] tog_q;
  assign wr = psel && penable && pwrite;
  assign mst = en_q && (md_q <= 3'h4);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      md_q <= 3'h7;
      pol_q <= 1'b0;
      select_pin_enable_q <= 1'b0;
      sck_d <= 1'b1;
      tog_q <= 5'h00;
    end
    else
    begin
      if (wr && paddr == OFS_MODE)
      begin
        en_q <= pwdata[EN_BIT];
        md_q <= pwdata[MODE_LO +: 3];
      end
      if (wr && paddr == OFS_CFG)
      begin
        pol_q <= pwdata[POL_BIT];
        select_pin_enable_q <= pwdata[SELECT_PIN_ENABLE_BIT];
      end
      sck_d <= sck_out;
      // toggles of the master clock within one busy stretch
      tog_q <= slave_select_n_out ? 5'h00 : tog_q + {4'h0, sck_out ^ sck_d};
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_release;
    !en_q && !$past(en_q) |-> sck_oe_n && sdo_oe_n && slave_select_n_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("pin driven while interface disabled");
  property p_float;
    !select_pin_enable_q && !$past(select_pin_enable_q) |-> slave_select_n_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("select pin driven with select enable low");
  property p_idle_sdo;
    mst && $past(mst) && slave_select_n_out |-> sdo_out && !sdo_oe_n;
  endproperty
  a_idle_sdo: assert property (p_idle_sdo)
    else $error("idle data output not driven high");
  property p_idle_sck;
    mst && $past(mst) && slave_select_n_out |-> sck_out == !pol_q;
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("idle clock level differs from polarity");
  property p_slave_clk;
    en_q && $past(en_q) && md_q == 3'h5 |-> sck_oe_n;
  endproperty
  a_slave_clk: assert property (p_slave_clk)
    else $error("clock pin driven in slave operation");
  property p_start;
    wr && paddr == OFS_DATA && mst && slave_select_n_out |=> !slave_select_n_out;
  endproperty
  a_start: assert property (p_start)
    else $error("data write did not start a transfer");
  property p_eight;
    mst && $rose(slave_select_n_out) |-> tog_q + {4'h0, sck_out ^ sck_d} == 5'h10;
  endproperty
  a_eight: assert property (p_eight)
    else $error("transfer did not have sixteen clock edges");
  property p_open_drain;
    !scl_out && !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("two-wire output drives high");
endmodule : sif_asserts

bind sif_top sif_asserts sif_asserts_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .sck_out, .sck_oe_n, .sdo_out, .sdo_oe_n,
  .slave_select_n_out, .slave_select_n_oe_n, .scl_out, .sda_out);

// [sif_spi_partner.sv]
`timescale 1ns/1ps
module sif_spi_partner (
  input wire logic sck_in,
  input wire logic sdo_pin,
  input wire logic slave_select_n_out,
  output logic sdi_in,
  output logic sck_drv,
  output logic ssel_drv
);
  // ----------------------------------------------------------------
  // far-end device, slave to the master or master to the slave
  // ----------------------------------------------------------------
  logic pol, edg, msb, mrole, act, sdo_h;
  logic [7:0] tx, rx, np;
  int bi;
  function automatic logic pick(input int i);
    return msb ? tx[7-i] : tx[i];
  endfunction : pick
  initial
  begin
    {pol, edg, msb, mrole, act} = 5'h04;
    {tx, rx, np} = 24'h000000;
    bi = 0;
    {sdi_in, sck_drv, ssel_drv} = 3'h7;
  end
  // lagging copies: data is taken as it stood before the edge
  always @(sdo_pin) sdo_h <= #10 sdo_pin;
  always @(slave_select_n_out) act <= #1 !slave_select_n_out;
  always @(negedge slave_select_n_out)
  begin
    np = 8'h00;
    bi = 0;
    if (!mrole)
    begin
      sdi_in = pick(0);
      bi = 1;
    end
  end
  // released line must not keep looking like data
  always @(posedge slave_select_n_out) if (!mrole) sdi_in = ~sdi_in;
  always @(sck_in)
    if (!mrole && act)
    begin
      if (sck_in === (pol == edg))
      begin
        rx = msb ? {rx[6:0], sdo_h} : {sdo_h, rx[7:1]};
        np = np + 8'h01;
        // next bit right after capture leaves a whole period for the
        // input synchroniser, even at the fastest master rate
        if (bi < 8)
        begin
          sdi_in = pick(bi);
          bi++;
        end
      end
    end
  task automatic run_master(input logic [7:0] b, output logic [7:0] r);
    mrole = 1'b1;
    tx = b;
    msb = 1'b1;
    ssel_drv = 1'b0;
    #1000;
    for (int i = 0; i < 8; i++)
    begin
      sck_drv = 1'b0;
      sdi_in = pick(i);
      #800;
      sck_drv = 1'b1;
      r = {r[6:0], sdo_pin};
      #800;
    end
    ssel_drv = 1'b1;
    sdi_in = ~sdi_in;
    #1000;
    mrole = 1'b0;
  endtask : run_master
endmodule : sif_spi_partner

// [serial_interface_module_spi_i2c_test.sv]
`timescale 1ns/1ps
module serial_interface_module_spi_i2c_test;
  import sif_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic sub_tick, timer_tick, scl_in, sda_in, sck_drv, ssel_drv, sdi_in;
  logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, scl_out, scl_oe_n;
  logic slave_select_n_out, slave_select_n_oe_n, sda_out, sda_oe_n;
  wire sck_in, sdo_pin, slave_select_n_in;
  int n_mismatch, comparisons, cyc;
  logic [1:0] tk;
  logic [7:0] rd;
  assign sck_in = sck_oe_n ? sck_drv : sck_out;
  assign sdo_pin = sdo_oe_n ? 1'bz : sdo_out;
  assign slave_select_n_in = slave_select_n_oe_n ? ssel_drv : slave_select_n_out;
  sif_top sif_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sub_tick, .timer_tick, .sck_in,
    .sck_out, .sck_oe_n, .sdi_in, .sdo_out, .sdo_oe_n, .slave_select_n_in,
    .slave_select_n_out, .slave_select_n_oe_n, .scl_in, .scl_out, .scl_oe_n,
    .sda_in, .sda_out, .sda_oe_n);
  sif_spi_partner sif_spi_partner_i (.sck_in, .sdo_pin, .slave_select_n_out,
    .sdi_in, .sck_drv, .ssel_drv);
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    tk <= tk + 2'h1;
    sub_tick <= (tk == 2'h3);
    timer_tick <= (tk == 2'h1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // bus access and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    comparisons++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_trf();
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, OFS_CFG, 8'h00);
      if (rd[TRF_BIT] === 1'b1) break;
    end
  endtask : wait_trf
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_off();
    apb(1'b1, OFS_MODE, RST_MODE);
    @(posedge pclk);
    chk("oe_n pins", 8'h1F, {3'h0, sck_oe_n, sdo_oe_n, slave_select_n_oe_n,
      scl_oe_n, sda_oe_n});
  endtask : t_off
  task automatic t_master(input logic [2:0] md, input logic pol, edg, msb,
    select_pin_enable, input logic [7:0] a, b);
    logic [7:0] cf;
    cf = {2'h0, pol, edg, msb, select_pin_enable, 2'h0};
    {sif_spi_partner_i.pol, sif_spi_partner_i.edg} = {pol, edg};
    sif_spi_partner_i.msb = msb;
    sif_spi_partner_i.tx = b;
    sif_spi_partner_i.sdi_in = msb ? b[7] : b[0];
    apb(1'b1, OFS_MODE, {md, 5'h00});
    apb(1'b1, OFS_CFG, cf);
    apb(1'b1, OFS_MODE, {md, 5'h02});
    @(posedge pclk);
    chk("idle sck", {7'h0, ~pol}, {7'h0, sck_out});
    chk("idle sdo", 8'h01, {7'h0, sdo_out});
    apb(1'b1, OFS_DATA, a);
    apb(1'b1, OFS_DATA, ~a);
    wait_trf();
    chk("flags", cf | 8'h03, rd);
    apb(1'b0, OFS_DATA, 8'h00);
    chk("rx data", b, rd);
    chk("far rx", a, sif_spi_partner_i.rx);
    chk("pulses", 8'h08, sif_spi_partner_i.np);
    apb(1'b1, OFS_CFG, cf);
    apb(1'b0, OFS_CFG, 8'h00);
    chk("cleared", cf, rd);
  endtask : t_master
  task automatic t_slave();
    logic [7:0] r;
    apb(1'b1, OFS_MODE, 8'hA0);
    apb(1'b1, OFS_CFG, 8'h0C);
    apb(1'b1, OFS_MODE, 8'hA2);
    apb(1'b1, OFS_DATA, 8'hC3);
    chk("slave sck oe_n", 8'h01, {7'h0, sck_oe_n});
    sif_spi_partner_i.run_master(8'h5A, r);
    wait_trf();
    chk("slave flags", 8'h0D, rd);
    apb(1'b0, OFS_DATA, 8'h00);
    chk("slave rx", 8'h5A, rd);
    chk("slave tx", 8'hC3, r);
    apb(1'b1, OFS_CFG, 8'h0C);
  endtask : t_slave
  initial
  begin
    {presetn, psel, penable, pwrite, sub_tick, timer_tick} = 6'h00;
    {scl_in, sda_in, paddr, tk, cyc} = {2'h3, 8'h00, 2'h0, 32'h0};
    pwdata = 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_MODE, 8'h00);
    chk("mode reset", RST_MODE, rd);
    apb(1'b0, OFS_CFG, 8'h00);
    chk("cfg reset", RST_ZERO, rd);
    t_off();
    t_master(3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'hA5, 8'h3C);
    t_master(3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h81, 8'hE7);
    t_master(3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 8'h12, 8'h69);
    t_master(3'h3, 1'b0, 1'b1, 1'b0, 1'b1, 8'hF0, 8'h0F);
    t_master(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 8'h6B, 8'hD4);
    t_slave();
    apb(1'b1, OFS_MODE, 8'hE2);
    apb(1'b1, OFS_DATA, 8'h55);
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_CFG, 8'h00);
    chk("unused mode flags", 8'h0C, rd);
    t_off();
    final_report();
  end
endmodule : serial_interface_module_spi_i2c_test
